// file: bioc_pkg.sv
// constants, field layout and config type of the bidirectional io_cell block
// ----------------------------------------------------------------------------
// Notes on behaviour
// - row block has five cells, 35 signals
// - column block has four cells, 28 signals
// - two core inputs; path a combinational or registered, path b combinational
// - six dedicated io clocks serve as register clocks
// - every cell selects its own control sources
// - input register clocked independently of output pair
// - output and oe registers share clock, enable
// - shared sync/async clear, per-register disable
// - one clear source per cell; preset or clear
// - each register powers up high or low
// - low start obeys async clear, high start async preset
// - synchronous reset acts on active register edge
// - input register takes one core path
// - each core path has its own delay
// - delays: pin-core, pin-inreg, outreg-pin
// ----------------------------------------------------------------------------
package bioc_pkg;

    // ------------------------------------------------------------------------
    // block geometry
    // ------------------------------------------------------------------------
    localparam int N_ROW_CELLS = 5;                  // cells in a row block
    localparam int N_COL_CELLS = 4;                  // cells in a column block
    localparam int N_IO_CLK    = 6;                  // dedicated io clocks
    localparam int DLY_TAPS    = 8;                  // delay settings 0..7 cycles
    localparam int ADDR_W      = 12;                 // apb address width

    // ------------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;   // control: configuration done
    localparam logic [11:0] ADDR_STATUS = 12'h004;   // register state of all cells
    localparam logic [11:0] ADDR_CELL0  = 12'h010;   // first cell config word
    localparam logic [11:0] CELL_STRIDE = 12'h004;   // spacing of cell config words
    localparam int          CTRL_DONE   = 0;         // bit: configuration complete
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------------------
    // register slots inside a cell and clock select codes
    // ------------------------------------------------------------------------
    localparam int          REG_IN      = 0;         // input register
    localparam int          REG_OUT     = 1;         // output register
    localparam int          REG_OE      = 2;         // output enable register
    localparam logic [2:0]  CLK_SEL_CORE = 3'h6;     // codes 6,7 pick core clock

    // per-cell configuration word, msb first
    typedef struct packed {
        logic [2:0] dly_out;                         // outreg to pin delay
        logic [2:0] dly_inreg;                       // pin to input register delay
        logic [2:0] dly_b;                           // pin to core, path b
        logic [2:0] dly_a;                           // pin to core, path a
        logic       in_reg_use;                      // path a carries input register
        logic [2:0] sclr_dis;                        // ignore sync clear, per reg
        logic [2:0] aclr_dis;                        // ignore async clear, per reg
        logic [2:0] powerup;                         // power-up level, per reg
        logic       preset_mode;                     // 1 preset, 0 clear
        logic       oe_force;                        // oe source: constant high
        logic       ce_out_force;                    // output pair enable forced
        logic       ce_in_force;                     // input enable forced
        logic [2:0] clk_out_sel;                     // output pair clock source
        logic [2:0] clk_in_sel;                      // input register clock source
    } bioc_cfg_type;

endpackage : bioc_pkg

// file: bioc_io_block.sv
// one io block of bidirectional cells with apb configuration
`timescale 1ns/100ps
module bioc_io_block #(
    parameter int NCELL = bioc_pkg::N_ROW_CELLS      // 5 row block, 4 column block
) (
    // clock and reset
    input  wire logic                         MCLK,
    input  wire logic                         NRST,
    // apb slave
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [bioc_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]                  PWDATA,
    output logic      [31:0]                  PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    // dedicated io clocks from the global network
    input  wire logic [bioc_pkg::N_IO_CLK-1:0] IO_CLK,
    // core logic side, one bit per cell
    input  wire logic [NCELL-1:0]             DATAOUT,
    input  wire logic [NCELL-1:0]             COE,
    input  wire logic [NCELL-1:0]             CCE_IN,
    input  wire logic [NCELL-1:0]             CCE_OUT,
    input  wire logic [NCELL-1:0]             CCLK,
    input  wire logic [NCELL-1:0]             CACLR,
    input  wire logic [NCELL-1:0]             CSCLR,
    output logic      [NCELL-1:0]             DATAIN_A,
    output logic      [NCELL-1:0]             DATAIN_B,
    // pin side
    input  wire logic [NCELL-1:0]             PAD_IN,
    output logic      [NCELL-1:0]             PAD_OUT,
    output logic      [NCELL-1:0]             PAD_OE
);
    import bioc_pkg::*;

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (NCELL != N_ROW_CELLS && NCELL != N_COL_CELLS) begin : g_bad_ncell
        $error("NCELL must be 4 or 5");
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // pick the tick of the selected clock source
    function automatic logic sel_tick(input logic [2:0] sel, input logic [N_IO_CLK-1:0] io_edge,
                                      input logic core_edge);
        sel_tick = (sel >= CLK_SEL_CORE) ? core_edge : io_edge[sel];
    endfunction : sel_tick

    // tap a delay line: 0 gives the undelayed value
    function automatic logic dly_tap(input logic [2:0] k, input logic now, input logic [DLY_TAPS-2:0] line);
        dly_tap = (k == 3'h0) ? now : line[k-3'h1];
    endfunction : dly_tap

    // next value of one cell register with clear, preset, enable
    function automatic logic reg_next(input logic cur, input logic d, input logic tick, input logic ce,
                                      input logic aclr, input logic sclr, input bioc_cfg_type c, input int r);
        logic can_async;
        can_async = (c.powerup[r] == c.preset_mode);
        if (aclr && !c.aclr_dis[r] && can_async) begin
            reg_next = c.preset_mode;
        end else if (tick && sclr && !c.sclr_dis[r]) begin
            reg_next = c.preset_mode;
        end else if (tick && ce) begin
            reg_next = d;
        end else begin
            reg_next = cur;
        end
    endfunction : reg_next

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [31:0]           ctrl;                      // control word
    bioc_cfg_type          cfg      [NCELL];          // per-cell configuration
    logic [2:0]            creg     [NCELL];          // in/out/oe registers
    logic [DLY_TAPS-2:0]   pin_line [NCELL];          // pin delay line
    logic [DLY_TAPS-2:0]   out_line [NCELL];          // output delay line
    logic [N_IO_CLK-1:0]   ioclk_s1, ioclk_s2, ioclk_q; // io clock sync and edge
    logic [NCELL-1:0]      pad_s1, pad_s2;            // pin synchroniser
    logic [NCELL-1:0]      cclk_q;                    // previous core clock
    logic                  done_q;                    // previous config done

    logic [31:0]           next_ctrl;
    bioc_cfg_type          next_cfg      [NCELL];
    logic [2:0]            next_creg     [NCELL];
    logic [DLY_TAPS-2:0]   next_pin_line [NCELL];
    logic [DLY_TAPS-2:0]   next_out_line [NCELL];
    logic [31:0]           next_prdata;
    logic                  next_pready, next_pslverr;
    logic [NCELL-1:0]      next_datain_a, next_datain_b, next_pad_out, next_pad_oe;

    logic [N_IO_CLK-1:0]   io_edge;                   // dedicated clock rising edges
    logic                  cfg_done;                  // configuration complete
    logic                  apb_acc;                   // access phase awaiting answer

    assign io_edge  = ioclk_s2 & ~ioclk_q;
    assign cfg_done = ctrl[CTRL_DONE];
    assign apb_acc  = PSEL && PENABLE && !PREADY;

    // ------------------------------------------------------------------------
    // apb register file
    // ------------------------------------------------------------------------
    // decode on every access cycle; the read answer is set up in the first one, while a
    // write lands only at the edge where the master samples pready high, never before it
    always_comb begin
        logic        hit;                             // address maps to a register
        logic        wr_now;                          // completing edge of a write
        logic [31:0] rd_word;                         // word at the decoded address
        hit           = 1'b0;
        wr_now        = PSEL && PENABLE && PREADY && PWRITE;
        rd_word       = 32'h0000_0000;
        next_ctrl     = ctrl;
        next_cfg      = cfg;
        next_pready   = apb_acc;
        if (PADDR == ADDR_CTRL) begin
            hit = 1'b1;
            rd_word = ctrl;
            if (wr_now) begin
                next_ctrl = {31'h0000_0000, PWDATA[CTRL_DONE]};
            end
        end else if (PADDR == ADDR_STATUS) begin
            hit = 1'b1;                               // read only, writes dropped
            for (int i = 0; i < NCELL; i++) begin
                rd_word[3*i +: 3] = creg[i];
            end
        end
        for (int i = 0; i < NCELL; i++) begin
            if (PADDR == ADDR_CELL0 + CELL_STRIDE * 12'(i)) begin
                hit = 1'b1;
                rd_word = cfg[i];
                if (wr_now) begin
                    next_cfg[i] = bioc_cfg_type'(PWDATA);
                end
            end
        end
        // read data stands only with pready; an unmapped address answers zero and an error
        next_prdata  = (apb_acc && hit) ? rd_word : 32'h0000_0000;
        next_pslverr = apb_acc && !hit;
    end

    // register the bus state
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctrl    <= CTRL_RESET;
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            for (int i = 0; i < NCELL; i++) begin
                cfg[i] <= bioc_cfg_type'(CFG_RESET);
            end
        end else begin
            ctrl    <= next_ctrl;
            PRDATA  <= next_prdata;
            PREADY  <= next_pready;
            PSLVERR <= next_pslverr;
            cfg     <= next_cfg;
        end
    end

    // ------------------------------------------------------------------------
    // cell registers, delay lines and pin drivers
    // ------------------------------------------------------------------------
    // compute every cell's next state
    always_comb begin
        for (int i = 0; i < NCELL; i++) begin
            logic tick_in, tick_out, ce_in, ce_out, pin_in, oe_d;
            tick_in  = sel_tick(cfg[i].clk_in_sel, io_edge, CCLK[i] & ~cclk_q[i]);
            tick_out = sel_tick(cfg[i].clk_out_sel, io_edge, CCLK[i] & ~cclk_q[i]);
            ce_in    = cfg[i].ce_in_force | CCE_IN[i];
            ce_out   = cfg[i].ce_out_force | CCE_OUT[i];
            pin_in   = dly_tap(cfg[i].dly_inreg, pad_s2[i], pin_line[i]);
            oe_d     = cfg[i].oe_force | COE[i];
            next_pin_line[i] = {pin_line[i][DLY_TAPS-3:0], pad_s2[i]};
            next_out_line[i] = {out_line[i][DLY_TAPS-3:0], creg[i][REG_OUT]};
            if (!cfg_done) begin
                next_creg[i] = cfg[i].powerup;
            end else begin
                // one shared clear/preset line drives all three registers
                next_creg[i][REG_IN]  = reg_next(creg[i][REG_IN], pin_in, tick_in, ce_in,
                                                 CACLR[i], CSCLR[i], cfg[i], REG_IN);
                next_creg[i][REG_OUT] = reg_next(creg[i][REG_OUT], DATAOUT[i], tick_out, ce_out,
                                                 CACLR[i], CSCLR[i], cfg[i], REG_OUT);
                next_creg[i][REG_OE]  = reg_next(creg[i][REG_OE], oe_d, tick_out, ce_out,
                                                 CACLR[i], CSCLR[i], cfg[i], REG_OE);
            end
            // path a: input register or delayed pin; path b: delayed pin
            next_datain_a[i] = cfg[i].in_reg_use ? creg[i][REG_IN]
                                                 : dly_tap(cfg[i].dly_a, pad_s2[i], pin_line[i]);
            next_datain_b[i] = dly_tap(cfg[i].dly_b, pad_s2[i], pin_line[i]);
            next_pad_out[i]  = dly_tap(cfg[i].dly_out, creg[i][REG_OUT], out_line[i]);
            next_pad_oe[i]   = cfg_done && creg[i][REG_OE];
        end
    end

    // register cells, synchronisers and outputs
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ioclk_s1 <= '0;
            ioclk_s2 <= '0;
            ioclk_q  <= '0;
            pad_s1   <= '0;
            pad_s2   <= '0;
            cclk_q   <= '0;
            done_q   <= 1'b0;
            DATAIN_A <= '0;
            DATAIN_B <= '0;
            PAD_OUT  <= '0;
            PAD_OE   <= '0;
            for (int i = 0; i < NCELL; i++) begin
                creg[i]     <= 3'h0;
                pin_line[i] <= '0;
                out_line[i] <= '0;
            end
        end else begin
            ioclk_s1 <= IO_CLK;
            ioclk_s2 <= ioclk_s1;
            ioclk_q  <= ioclk_s2;
            pad_s1   <= PAD_IN;
            pad_s2   <= pad_s1;
            cclk_q   <= CCLK;
            done_q   <= cfg_done;
            DATAIN_A <= next_datain_a;
            DATAIN_B <= next_datain_b;
            PAD_OUT  <= next_pad_out;
            PAD_OE   <= next_pad_oe;
            creg     <= next_creg;
            pin_line <= next_pin_line;
            out_line <= next_out_line;
        end
    end

    // ------------------------------------------------------------------------
    // assertions on cells 0 and 1 and on the bus
    // ------------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    a_pad_oe_follow: assert property (cfg_done && $past(cfg_done) |-> PAD_OE[0] == $past(creg[0][REG_OE]))
        else $error("pin enable does not follow oe register");
    // done_q is the done bit that the pin driver stage saw one edge back
    a_oe_off_unconf: assert property (!done_q |-> !PAD_OE[0])
        else $error("pin driven before configuration done");
    a_powerup_level: assert property (!cfg_done ##1 !cfg_done |-> creg[0] == $past(cfg[0].powerup))
        else $error("register not at power-up level");
    a_async_clear: assert property (cfg_done && CACLR[0] && !cfg[0].aclr_dis[REG_OUT]
        && cfg[0].powerup[REG_OUT] == cfg[0].preset_mode |=> creg[0][REG_OUT] == $past(cfg[0].preset_mode))
        else $error("async clear or preset ignored");
    a_async_blocked: assert property (cfg_done && CACLR[0] && !CSCLR[0]
        && !CCE_OUT[0] && !cfg[0].ce_out_force
        && cfg[0].powerup[REG_OUT] != cfg[0].preset_mode |=> $stable(creg[0][REG_OUT]))
        else $error("async action on mismatched start level");
    a_hold_no_ce: assert property (cfg_done && !CACLR[0] && !CSCLR[0] && !CCE_IN[0]
        && !cfg[0].ce_in_force |=> $stable(creg[0][REG_IN]))
        else $error("input register changed without enable");
    // cell 1 is the one set up with a registered path a and a delayed path b
    a_path_b_delay: assert property (cfg[1].dly_b == 3'h2 && $stable(cfg[1]) [*4]
        |-> DATAIN_B[1] == $past(pad_s2[1], 3))
        else $error("path b delay wrong");
    a_path_a_inreg: assert property (cfg[1].in_reg_use && $stable(cfg[1].in_reg_use)
        |-> DATAIN_A[1] == $past(creg[1][REG_IN]))
        else $error("path a does not carry input register");
    // sync clear on a core clock tick wins over a data load
    a_sync_clear: assert property (cfg_done && CSCLR[0] && !CACLR[0] && !cfg[0].sclr_dis[REG_OUT]
        && cfg[0].clk_out_sel >= CLK_SEL_CORE && CCLK[0] && !cclk_q[0]
        |=> creg[0][REG_OUT] == $past(cfg[0].preset_mode))
        else $error("sync clear ignored on output register");
    a_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("apb access not answered in one cycle");
    // the answer stands for one cycle only
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("apb answer stands too long");
    // an error answer carries no data
    a_error_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
        else $error("error answer without ready or with data");

    c_pin_driven:  cover property (cfg_done ##1 PAD_OE[0] ##1 PAD_OUT[0]);
    c_async_clear: cover property (cfg_done && CACLR[0] ##1 creg[0] == 3'h0);
    c_inreg_path:  cover property (cfg[0].in_reg_use && DATAIN_A[0] && !DATAIN_B[0]);
    c_cfg_write:   cover property (PSEL && PENABLE && PWRITE && PREADY && !PSLVERR);

endmodule : bioc_io_block

// file: bioc_core_model.sv
// behavioural model of the core logic that drives one io block
`timescale 1ns/100ps
module bioc_core_model #(
    parameter int NCELL = 5                          // cells in the block
) (
    // clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  NRST,
    // bench requests: data, oe, ce_in, ce_out, sclr, aclr
    input  wire logic [5:0][NCELL-1:0] CTL,
    input  wire logic                  TICK,
    // core side of the io block
    output logic      [NCELL-1:0]      DATAOUT,
    output logic      [NCELL-1:0]      COE,
    output logic      [NCELL-1:0]      CCE_IN,
    output logic      [NCELL-1:0]      CCE_OUT,
    output logic      [NCELL-1:0]      CCLK,
    output logic      [NCELL-1:0]      CACLR,
    output logic      [NCELL-1:0]      CSCLR
);
    logic [5:0][NCELL-1:0] ctl_q, next_ctl_q;        // registered control lines
    logic [1:0]            cnt, next_cnt;            // core clock pulse counter
    // next values: lines follow requests, a tick starts one clock pulse
    always_comb begin
        next_ctl_q = CTL;
        next_cnt   = TICK ? 2'h3 : ((cnt != 2'h0) ? cnt - 2'h1 : 2'h0);
    end
    // registers only
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctl_q <= '0;
            cnt   <= 2'h0;
        end else begin
            ctl_q <= next_ctl_q;
            cnt   <= next_cnt;
        end
    end
    // one clear line of each kind per cell, shared by all its registers
    assign DATAOUT = ctl_q[0];
    assign COE     = ctl_q[1];
    assign CCE_IN  = ctl_q[2];
    assign CCE_OUT = ctl_q[3];
    assign CSCLR   = ctl_q[4];
    assign CACLR   = ctl_q[5];
    // core clock stands still low outside a pulse, high two cycles per tick
    assign CCLK    = {NCELL{(cnt == 2'h2) || (cnt == 2'h1)}};
endmodule : bioc_core_model

// file: bioc_io_block_tb.sv
// self-checking testbench of the io block with a core logic model
`timescale 1ns/100ps
module bioc_io_block_tb;
    import bioc_pkg::*;
    logic                  mclk, nrst, psel, penable, pwrite, tick;   // clock, reset, apb, tick
    logic [11:0]           paddr;                                     // apb address
    logic [31:0]           pwdata, prdata;                            // apb data
    logic                  pready, pslverr;                           // apb answer
    logic [5:0]            io_clk;                                    // dedicated clocks
    logic [2:0]            div;                                       // io clock divider
    logic [5:0][4:0]       ctl;                                       // requests to core model
    logic [4:0]            dout, coe, cce_in, cce_out, cclk, caclr, csclr, din_a, din_b, pin, pad_out, pad_oe;
    logic [32:0]           expq[$];                                   // expected read answers
    bioc_cfg_type          c0, c1;                                    // cell config words
    int                    n_errors, n_checks;                        // counters
    // clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // dedicated io clocks: three cycles high, three low
    always @(posedge mclk) begin
        div <= (div == 3'h2) ? 3'h0 : div + 3'h1;
        if (div == 3'h2) io_clk <= ~io_clk;
    end
    bioc_core_model #(.NCELL(5)) bioc_core_model_inst (.MCLK(mclk), .NRST(nrst), .CTL(ctl), .TICK(tick),
        .DATAOUT(dout), .COE(coe), .CCE_IN(cce_in), .CCE_OUT(cce_out), .CCLK(cclk), .CACLR(caclr), .CSCLR(csclr));
    bioc_io_block #(.NCELL(5)) bioc_io_block_inst (.MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IO_CLK(io_clk), .DATAOUT(dout), .COE(coe), .CCE_IN(cce_in), .CCE_OUT(cce_out), .CCLK(cclk),
        .CACLR(caclr), .CSCLR(csclr), .DATAIN_A(din_a), .DATAIN_B(din_b), .PAD_IN(pin), .PAD_OUT(pad_out),
        .PAD_OE(pad_oe));
    // verdict and end of run
    task automatic close_out();
        if (expq.size() != 0) n_errors++;                                   // a read never answered
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // compare one value
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask : cmp
    // apb transfer; a read notes its expected {error, data}; pready is sampled at rising edges
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        @(posedge mclk);
        if (!wr) expq.push_back(e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog limits this wait
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // set cell 0 controls, optionally give one core clock tick, let it settle
    task automatic cell0(input logic [5:0] c, input logic t);
        @(posedge mclk);
        for (int k = 0; k < 6; k++) ctl[k] <= {4'h0, c[k]};
        repeat (3) @(posedge mclk);
        tick <= t;
        @(posedge mclk);
        tick <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask : cell0
    // answer monitor: the oldest note meets each read answer
    always @(negedge mclk) begin
        if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0) begin
            cmp(expq.pop_front(), {pslverr, prdata});
        end
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        close_out();
    end
    // main sequence
    initial begin
        {nrst, psel, penable, pwrite, tick, paddr, pwdata, io_clk, div, ctl, pin} = '0;
        n_errors = 0;
        n_checks = 0;
        void'($urandom(38254));
        c0 = '0;
        c0.clk_out_sel = CLK_SEL_CORE;
        c0.clk_in_sel  = CLK_SEL_CORE;
        c0.sclr_dis    = 3'h4;
        c1 = '0;
        c1.in_reg_use  = 1'b1;
        c1.ce_in_force = 1'b1;
        c1.dly_b       = 3'h2;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        apb(1'b0, ADDR_CTRL, 32'h0, {1'b0, CTRL_RESET});
        apb(1'b0, ADDR_CELL0, 32'h0, {1'b0, CFG_RESET});
        apb(1'b0, 12'h0FC, 32'h0, 33'h1_0000_0000);
        apb(1'b1, ADDR_CELL0, 32'(c0), 33'h0);
        apb(1'b1, ADDR_CELL0 + CELL_STRIDE, 32'(c1), 33'h0);
        apb(1'b0, ADDR_CELL0, 32'h0, {1'b0, 32'(c0)});
        apb(1'b1, ADDR_CTRL, 32'h1, 33'h0);
        // both core paths follow the pin, the registered one by the io clock
        repeat (3) begin
            @(posedge mclk);
            pin <= 5'($urandom);
            repeat (20) @(posedge mclk);
            cmp({28'h0, pin}, {28'h0, din_a});
            cmp({28'h0, pin}, {28'h0, din_b});
        end
        // output pair loads on the core clock and drives the pin
        cell0(6'b00_1111, 1'b1);
        cmp({31'h0, pad_oe[0], pad_out[0]}, 33'h3);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 2'b11, pin[0]});
        // enables low: nothing changes on the tick
        cell0(6'b00_0000, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 2'b11, pin[0]});
        // sync clear wins over a load; oe register ignores it
        cell0(6'b01_1111, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 3'b100});
        // async clear acts without a tick
        cell0(6'b10_0000, 1'b0);
        cmp({32'h0, pad_oe[0]}, 33'h0);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 3'b000});
        // power-up high level shows while configuration is not done
        cell0(6'b00_0000, 1'b0);
        c0.powerup     = 3'h7;
        c0.preset_mode = 1'b1;
        apb(1'b1, ADDR_CELL0, 32'(c0), 33'h0);
        apb(1'b1, ADDR_CTRL, 32'h0, 33'h0);
        apb(1'b0, ADDR_STATUS, 32'h0, 33'h7);
        cmp({28'h0, pad_oe}, 33'h0);
        // high start: async preset acts; in clear mode the line is then ignored
        apb(1'b1, ADDR_CTRL, 32'h1, 33'h0);
        cell0(6'b00_1100, 1'b1);
        cell0(6'b10_0000, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 3'b111});
        cmp({31'h0, pad_oe[0], pad_out[0]}, 33'h3);
        c0.preset_mode = 1'b0;
        apb(1'b1, ADDR_CELL0, 32'(c0), 33'h0);
        cell0(6'b00_1100, 1'b1);
        cell0(6'b10_0000, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0, {29'h0, pin[1], 2'b00, pin[0]});
        repeat (4) @(posedge mclk);
        close_out();
    end
endmodule : bioc_io_block_tb
